// *** inc/smi_pkg.sv ***
// package: register map, field layout and state types of the smi aggregator
// assumes: 8-bit register port, one clock, standby reset as the async reset
package smi_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] STS1_OFS = 8'h14;
    localparam logic [7:0] STS2_OFS = 8'h15;
    localparam logic [7:0] STS3_OFS = 8'h16;
    localparam logic [7:0] STS4_OFS = 8'h17;
    localparam logic [7:0] EN1_OFS  = 8'h18;
    localparam logic [7:0] EN2_OFS  = 8'h19;
    localparam logic [7:0] EN3_OFS  = 8'h1A;
    localparam logic [7:0] EN4_OFS  = 8'h1B;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] STS1_RESET = 8'h02;
    localparam logic [7:0] EN_RESET   = 8'h00;

    // ****************************************************************
    // implemented and write-one-to-clear bit masks
    // ****************************************************************
    localparam logic [7:0] STS1_W1C_MASK   = 8'h01;
    localparam logic [7:0] STS2_W1C_MASK   = 8'h10;
    localparam logic [7:0] STS3_W1C_MASK   = 8'hFE;
    localparam logic [7:0] STS4_BASE_MASK  = 8'hAF;
    localparam logic [7:0] STS4_SIX_MASK   = 8'h50;
    localparam logic [7:0] EN1_MASK        = 8'h9F;
    localparam logic [7:0] EN2_MASK        = 8'hF7;
    localparam logic [7:0] EN2_SRC_MASK    = 8'h17;
    localparam logic [7:0] EN3_MASK        = 8'hFE;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BAT_BIT       = 0;
    localparam int PAR_BIT       = 1;
    localparam int IR_BIT        = 10;
    localparam int CLICK_BIT     = 12;
    localparam int ROUTE_PME_BIT = 5;
    localparam int ROUTE_SER_BIT = 6;
    localparam int ROUTE_PIN_BIT = 7;
    localparam int FLAG_W        = 32;
    localparam int PIN_EVENTS    = 11;

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] en4;
        logic [7:0] mirror1;
        logic [7:0] mirror2;
        logic [7:0] rdata;
        logic       group_n;
        logic       pin_n;
        logic       serirq;
        logic       pme;
        logic       strap_done;
        logic       main_rst_d;
    } smi_top_state_t;

endpackage

// *** inc/smi_flag_if.sv ***
// interface: set, clear and flag vectors between the aggregator and its flag bank
// assumes: owner drives set and clear combinationally, bank registers flags
interface smi_flag_if #(parameter int W = 32);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] flags;
    modport bank  (input set, input clr, output flags);
    modport owner (output set, output clr, input flags);
endinterface

// *** src/smi_flag_bank.sv ***
// sticky flag bank: each sticky bit is set by hardware, cleared by request
// assumes: set and clear arrive synchronous to clk_in; set wins over clear
module smi_flag_bank #(
    parameter logic [31:0] STICKY = 32'h0000_0000
) (
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    smi_flag_if.bank      flag_io
);
    typedef struct packed {
        logic [31:0] flags;
    } smi_bank_state_t;

    smi_bank_state_t st_reg;
    smi_bank_state_t st_next;
    logic [31:0]     bit_next;

    // non-sticky positions stay zero so the owner can or in mirrors
    for (genvar i = 0; i < 32; i++) begin : g_bit
        assign bit_next[i] = STICKY[i] &
                             (flag_io.set[i] | (st_reg.flags[i] & ~flag_io.clr[i]));
    end

    always_comb begin
        st_next       = st_reg;
        st_next.flags = bit_next;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag_io.flags = st_reg.flags;
endmodule

// *** src/smi_toggle_detect.sv ***
// toggle detector: one-cycle pulse on any change of each input bit
// assumes: inputs synchronous to clk_in; no pulse in the first cycle after reset
module smi_toggle_detect #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] level_in,
    output logic      [W-1:0] toggle_out
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic         armed;
    } smi_tog_state_t;

    smi_tog_state_t st_reg;
    smi_tog_state_t st_next;

    // armed keeps the level seen at reset release from counting as an edge
    for (genvar i = 0; i < W; i++) begin : g_tog
        assign toggle_out[i] = st_reg.armed & (level_in[i] ^ st_reg.prev[i]);
    end

    always_comb begin
        st_next       = st_reg;
        st_next.prev  = level_in;
        st_next.armed = 1'b1;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// *** src/smi_status_enable_aggregator.sv ***
// smi aggregator: status and enable registers, group smi and its three routes
// assumes: RESET_IN is the standby-power reset, MAIN_RESET_IN a synchronous level,
// all source inputs synchronous to REF_CLK_IN
//
// The implementer's own choice: the address-and-strobe port.

// Overview of operation
// - battery-low flag clears only on software write of one to bit 0.
// - at standby reset release, battery replaced or below 1.2V sets battery flag.
// - at main reset release, battery sag below 2.4V sets battery flag.
// - parallel status reads one when port inactive, else follows acknowledge input.
// - uart1, uart2, floppy, watchdog status bits are read-only source mirrors.
// - mouse and keyboard status bits mirror their sources, read-only.
// - any infrared receive transition sets flag; reading status two clears it.
// - mouse-click wake flag clears on software write of one.
// - status three holds seven write-one-to-clear pin flags, bit 0 reserved.
// - status four holds uart3-6 and pin write-one-to-clear flags.
// - enable one gates battery, parallel, uarts, floppy, watchdog into group.
// - enable registers reset to zero on standby reset.
// - enable two gates mouse, keyboard, infrared, click wake into group.
// - enable two bits 5, 6, 7 route group to pme, serial irq, pin.
// - enable three gates status three pin flags bit for bit.
// - enable four gates status four flags bit for bit.
module smi_status_enable_aggregator #(
    parameter logic SIX_PORT_BUILD = 1'b1
) (
    // clock and resets
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        MAIN_RESET_IN,
    // battery monitor
    input  wire logic        BATT_VBAT_EVENT_IN,
    input  wire logic        BATT_SAG_IN,
    // mirrored sources
    input  wire logic        PAR_ACTIVE_IN,
    input  wire logic        PAR_ACK_N_IN,
    input  wire logic        UART1_IRQ_IN,
    input  wire logic        UART2_IRQ_IN,
    input  wire logic        FLOPPY_IRQ_IN,
    input  wire logic        WATCHDOG_IN,
    input  wire logic        MOUSE_IRQ_IN,
    input  wire logic        KEYBOARD_IRQ_IN,
    // latched sources
    input  wire logic        IR_RX_IN,
    input  wire logic        CLICK_WAKE_IN,
    input  wire logic [3:0]  UART_HI_IRQ_IN,
    input  wire logic [10:0] PIN_EVENT_IN,
    // register port
    input  wire logic [7:0]  REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    // group smi routes
    output logic             SMI_GROUP_N_OUT,
    output logic             SMI_PIN_N_OUT,
    output logic             SMI_SERIRQ_OUT,
    output logic             SMI_PME_OUT
);

    // ****************************************************************
    // constants
    // ****************************************************************
    localparam logic [7:0]  STS4_W1C_MASK = smi_pkg::STS4_BASE_MASK |
                                            (SIX_PORT_BUILD ? smi_pkg::STS4_SIX_MASK : 8'h00);
    localparam logic [31:0] STICKY_MASK   = {STS4_W1C_MASK, smi_pkg::STS3_W1C_MASK,
                                             8'h14, smi_pkg::STS1_W1C_MASK};
    localparam logic [7:0]  EN4_MASK      = STS4_W1C_MASK;

    // ****************************************************************
    // declarations
    // ****************************************************************
    smi_pkg::smi_top_state_t st_reg;
    smi_pkg::smi_top_state_t st_next;
    smi_flag_if #(.W(smi_pkg::FLAG_W)) flag_io ();

    logic        ir_toggle;
    logic        bat_set;
    logic        par_bit;
    logic [7:0]  status1;
    logic [7:0]  status2;
    logic [7:0]  status3;
    logic [7:0]  status4;
    logic        any_enabled;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;

    // ****************************************************************
    // leaf instances
    // ****************************************************************
    smi_toggle_detect #(
        .W (1)
    ) u_ir_toggle (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RESET_IN),
        .level_in   (IR_RX_IN),
        .toggle_out (ir_toggle)
    );

    smi_flag_bank #(
        .STICKY (STICKY_MASK)
    ) u_flags (
        .clk_in  (REF_CLK_IN),
        .rst_in  (RESET_IN),
        .flag_io (flag_io)
    );

    // ****************************************************************
    // event sources into the sticky flags
    // ****************************************************************
    // strap caught in the first clocked cycle after release, never under reset
    assign bat_set = (~st_reg.strap_done & BATT_VBAT_EVENT_IN) |
                     (st_reg.main_rst_d & ~MAIN_RESET_IN & BATT_SAG_IN);

    always_comb begin
        set_vec                     = 32'h0000_0000;
        set_vec[smi_pkg::BAT_BIT]   = bat_set;
        set_vec[smi_pkg::IR_BIT]    = ir_toggle;
        set_vec[smi_pkg::CLICK_BIT] = CLICK_WAKE_IN;
        // status three: a, b, f, g, h, i, j at bits 1..7
        set_vec[23:16] = {PIN_EVENT_IN[9:5], PIN_EVENT_IN[1:0], 1'b0};
        // status four: uart3, uart4, c, d, uart5, e, uart6, k
        set_vec[31:24] = {PIN_EVENT_IN[10], UART_HI_IRQ_IN[3] & SIX_PORT_BUILD,
                          PIN_EVENT_IN[4], UART_HI_IRQ_IN[2] & SIX_PORT_BUILD,
                          PIN_EVENT_IN[3:2], UART_HI_IRQ_IN[1:0]};
    end

    // ****************************************************************
    // clear requests from the register port
    // ****************************************************************
    // only ones clear, and only at implemented bits
    always_comb begin
        clr_vec = 32'h0000_0000;
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                smi_pkg::STS1_OFS: begin
                    clr_vec[7:0] = REG_WDATA_IN & smi_pkg::STS1_W1C_MASK;
                end
                smi_pkg::STS2_OFS: begin
                    clr_vec[15:8] = REG_WDATA_IN & smi_pkg::STS2_W1C_MASK;
                end
                smi_pkg::STS3_OFS: begin
                    clr_vec[23:16] = REG_WDATA_IN & smi_pkg::STS3_W1C_MASK;
                end
                smi_pkg::STS4_OFS: begin
                    clr_vec[31:24] = REG_WDATA_IN & STS4_W1C_MASK;
                end
                default: begin
                end
            endcase
        end
        // read-clear of infrared; a toggle in the same cycle still wins
        if (REG_RD_IN && (REG_ADDR_IN == smi_pkg::STS2_OFS)) begin
            clr_vec[smi_pkg::IR_BIT] = 1'b1;
        end
    end

    assign flag_io.set = set_vec;
    assign flag_io.clr = clr_vec;

    // ****************************************************************
    // status view
    // ****************************************************************
    assign par_bit = PAR_ACTIVE_IN ? PAR_ACK_N_IN : 1'b1;
    assign status1 = st_reg.mirror1 | flag_io.flags[7:0];
    assign status2 = st_reg.mirror2 | flag_io.flags[15:8];
    assign status3 = flag_io.flags[23:16];
    assign status4 = flag_io.flags[31:24];

    assign any_enabled = |(status1 & st_reg.en1) |
                         |(status2 & st_reg.en2 & smi_pkg::EN2_SRC_MASK) |
                         |(status3 & st_reg.en3) |
                         |(status4 & st_reg.en4);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next            = st_reg;
        st_next.strap_done = 1'b1;
        st_next.main_rst_d = MAIN_RESET_IN;
        // bits 5 and 6 reserved and zero
        st_next.mirror1    = {WATCHDOG_IN, 2'h0, FLOPPY_IRQ_IN,
                              UART1_IRQ_IN, UART2_IRQ_IN, par_bit, 1'b0};
        st_next.mirror2    = {6'h00, KEYBOARD_IRQ_IN, MOUSE_IRQ_IN};

        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                smi_pkg::EN1_OFS: begin
                    st_next.en1 = REG_WDATA_IN & smi_pkg::EN1_MASK;
                end
                smi_pkg::EN2_OFS: begin
                    st_next.en2 = REG_WDATA_IN & smi_pkg::EN2_MASK;
                end
                smi_pkg::EN3_OFS: begin
                    st_next.en3 = REG_WDATA_IN & smi_pkg::EN3_MASK;
                end
                smi_pkg::EN4_OFS: begin
                    st_next.en4 = REG_WDATA_IN & EN4_MASK;
                end
                default: begin
                end
            endcase
        end

        // read data stand one cycle only; unmapped reads give zero
        st_next.rdata = 8'h00;
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                smi_pkg::STS1_OFS: st_next.rdata = status1;
                smi_pkg::STS2_OFS: st_next.rdata = status2;
                smi_pkg::STS3_OFS: st_next.rdata = status3;
                smi_pkg::STS4_OFS: st_next.rdata = status4;
                smi_pkg::EN1_OFS:  st_next.rdata = st_reg.en1;
                smi_pkg::EN2_OFS:  st_next.rdata = st_reg.en2;
                smi_pkg::EN3_OFS:  st_next.rdata = st_reg.en3;
                smi_pkg::EN4_OFS:  st_next.rdata = st_reg.en4;
                default:           st_next.rdata = 8'h00;
            endcase
        end

        // routes are independent; all three may be on together
        st_next.group_n = ~any_enabled;
        st_next.pin_n   = ~(any_enabled & st_reg.en2[smi_pkg::ROUTE_PIN_BIT]);
        st_next.serirq  = any_enabled & st_reg.en2[smi_pkg::ROUTE_SER_BIT];
        st_next.pme     = any_enabled & st_reg.en2[smi_pkg::ROUTE_PME_BIT];
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st_reg            <= '0;
            st_reg.en1        <= smi_pkg::EN_RESET;
            st_reg.en2        <= smi_pkg::EN_RESET;
            st_reg.en3        <= smi_pkg::EN_RESET;
            st_reg.en4        <= smi_pkg::EN_RESET;
            st_reg.mirror1    <= smi_pkg::STS1_RESET;
            st_reg.group_n    <= 1'b1;
            st_reg.pin_n      <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA_OUT   = st_reg.rdata;
    assign SMI_GROUP_N_OUT = st_reg.group_n;
    assign SMI_PIN_N_OUT   = st_reg.pin_n;
    assign SMI_SERIRQ_OUT  = st_reg.serirq;
    assign SMI_PME_OUT     = st_reg.pme;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);

    a_bat_clear_one: assert property (
        (REG_WR_IN && REG_ADDR_IN == smi_pkg::STS1_OFS && REG_WDATA_IN[0] && !bat_set)
        |=> !flag_io.flags[smi_pkg::BAT_BIT])
        else $error("battery flag not cleared by write of one");

    a_bat_hold_flag: assert property (
        (flag_io.flags[smi_pkg::BAT_BIT] &&
         !(REG_WR_IN && REG_ADDR_IN == smi_pkg::STS1_OFS && REG_WDATA_IN[0]))
        |=> flag_io.flags[smi_pkg::BAT_BIT])
        else $error("battery flag lost without a clearing write");

    a_bat_main_set: assert property (
        ($fell(MAIN_RESET_IN) && BATT_SAG_IN) |=> flag_io.flags[smi_pkg::BAT_BIT])
        else $error("battery sag not latched at main reset release");

    // mirror checks skip a cycle whose previous edge was still under reset
    a_par_follow_ack: assert property (
        1'b1 ##1 !$past(RESET_IN) |-> st_reg.mirror1[smi_pkg::PAR_BIT] ==
            ($past(PAR_ACTIVE_IN) ? $past(PAR_ACK_N_IN) : 1'b1))
        else $error("parallel status does not follow acknowledge");

    a_ir_edge_set: assert property (
        ($changed(IR_RX_IN) && $past(u_ir_toggle.st_reg.armed))
        |=> status2[2])
        else $error("infrared transition not latched");

    a_ir_read_clear: assert property (
        (REG_RD_IN && REG_ADDR_IN == smi_pkg::STS2_OFS && !ir_toggle)
        |=> !flag_io.flags[smi_pkg::IR_BIT])
        else $error("infrared flag not cleared by status read");

    a_group_follows: assert property (
        any_enabled |=> !SMI_GROUP_N_OUT ##0 (SMI_PIN_N_OUT != st_reg.en2[7] ||
                                              $changed(st_reg.en2)))
        else $error("group smi not asserted for enabled status");

    a_pin_needs_group: assert property (
        (!SMI_PIN_N_OUT || SMI_SERIRQ_OUT || SMI_PME_OUT) |-> !SMI_GROUP_N_OUT)
        else $error("smi route active without group smi");

    a_en_stable_nowr: assert property (
        !(REG_WR_IN && REG_ADDR_IN == smi_pkg::EN1_OFS) |=> $stable(st_reg.en1))
        else $error("enable one changed without a write");

    a_rdata_one_cycle: assert property (
        !REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data present without a read");

    a_mouse_mirror: assert property (
        1'b1 ##1 !$past(RESET_IN) |-> status2[1:0] == $past({KEYBOARD_IRQ_IN, MOUSE_IRQ_IN}))
        else $error("mouse or keyboard status not mirrored");

    a_click_clear_one: assert property (
        (REG_WR_IN && REG_ADDR_IN == smi_pkg::STS2_OFS && REG_WDATA_IN[4] && !CLICK_WAKE_IN)
        |=> !flag_io.flags[smi_pkg::CLICK_BIT])
        else $error("click wake flag not cleared by write of one");

    // set checks skip an edge at which reset was still sampled high
    a_click_wake_set: assert property (
        (!RESET_IN && CLICK_WAKE_IN) |=> flag_io.flags[smi_pkg::CLICK_BIT])
        else $error("click wake event not latched");

    a_pin_event_set: assert property (
        (!RESET_IN && PIN_EVENT_IN[0]) |=> status3[1])
        else $error("pin event not latched in status three");

    a_uart_hi_set: assert property (
        (!RESET_IN && UART_HI_IRQ_IN[0]) |=> status4[0])
        else $error("uart3 event not latched in status four");

    a_en_reset_zero: assert property (
        $past(RESET_IN) |-> {st_reg.en1, st_reg.en2, st_reg.en3, st_reg.en4} == 32'h0000_0000)
        else $error("enable registers not zero after standby reset");

    a_route_pme_on: assert property (
        (any_enabled && st_reg.en2[smi_pkg::ROUTE_PME_BIT]) |=> SMI_PME_OUT)
        else $error("group smi not routed to pme");

    a_route_ser_on: assert property (
        (any_enabled && st_reg.en2[smi_pkg::ROUTE_SER_BIT]) |=> SMI_SERIRQ_OUT)
        else $error("group smi not routed to serial irq");

    a_group_release: assert property (
        !any_enabled |=> SMI_GROUP_N_OUT)
        else $error("group smi held without an enabled status bit");

endmodule

// *** tb/smi_status_enable_aggregator_test.sv ***
// testbench: register-port tasks and event sequences for the smi aggregator
// assumes: default six-port build, one 25 MHz clock, standby reset held 10 cycles
module smi_status_enable_aggregator_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals and design
    // ****************************************************************
    logic        clk, rst, main_rst, vbat_evt, sag, par_act, par_ack_n, ir, click;
    logic        u1, u2, fdc, wdt, ms, kb, wr, rd, grp_n, pin_n, ser, pme;
    logic [3:0]  uhi;
    logic [10:0] pins;
    logic [7:0]  addr, wdata, rdata;
    logic [7:0]  rst_exp [9] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  en_exp [4]  = '{8'h9F, 8'hF7, 8'hFE, 8'hFF};
    int          err_count, tests_run, cycles;

    smi_status_enable_aggregator i_smi_status_enable_aggregator (
        .REF_CLK_IN(clk), .RESET_IN(rst), .MAIN_RESET_IN(main_rst),
        .BATT_VBAT_EVENT_IN(vbat_evt), .BATT_SAG_IN(sag), .PAR_ACTIVE_IN(par_act),
        .PAR_ACK_N_IN(par_ack_n), .UART1_IRQ_IN(u1), .UART2_IRQ_IN(u2), .FLOPPY_IRQ_IN(fdc),
        .WATCHDOG_IN(wdt), .MOUSE_IRQ_IN(ms), .KEYBOARD_IRQ_IN(kb), .IR_RX_IN(ir),
        .CLICK_WAKE_IN(click), .UART_HI_IRQ_IN(uhi), .PIN_EVENT_IN(pins),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdata), .SMI_GROUP_N_OUT(grp_n), .SMI_PIN_N_OUT(pin_n),
        .SMI_SERIRQ_OUT(ser), .SMI_PME_OUT(pme));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // hang guard: whole run is a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        // return on a rising edge so the caller's stimulus lands there
        @(posedge clk);
    endtask

    // outputs in order group_n, pin_n, serirq, pme; two-edge latency plus margin
    task automatic chk_out(input logic [3:0] exp);
        cyc(3);
        #1 chk({4'h0, grp_n, pin_n, ser, pme}, {4'h0, exp});
        @(posedge clk);
    endtask

    task automatic test_done();
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {rst, main_rst, vbat_evt, sag, par_act, par_ack_n, ir, click} = 8'h80;
        {u1, u2, fdc, wdt, ms, kb, wr, rd} = 8'h00;
        {uhi, pins, addr, wdata} = '0;
        cyc(10);
        rst <= 1'b0;
        wr_reg(8'h1C, 8'hFF);
        for (int i = 0; i < 9; i++) rd_reg(8'(8'h14 + i), rst_exp[i]);
        chk_out(4'hC);
        $display("test reset done");
        for (int i = 0; i < 4; i++) wr_reg(8'(8'h18 + i), 8'hFF);
        for (int i = 0; i < 4; i++) rd_reg(8'(8'h18 + i), en_exp[i]);
        chk_out(4'h3);
        wr_reg(8'h19, 8'h00);
        chk_out(4'h4);
        wr_reg(8'h19, 8'h20);
        chk_out(4'h5);
        wr_reg(8'h19, 8'h40);
        chk_out(4'h6);
        wr_reg(8'h19, 8'h80);
        chk_out(4'h0);
        for (int i = 0; i < 4; i++) wr_reg(8'(8'h18 + i), 8'h00);
        chk_out(4'hC);
        $display("test enables done");
        {u1, u2, fdc, wdt, ms, kb, par_act} <= 7'h7F;
        cyc(3);
        rd_reg(8'h14, 8'h9C);
        rd_reg(8'h15, 8'h03);
        wr_reg(8'h14, 8'hFE);
        wr_reg(8'h15, 8'hFF);
        rd_reg(8'h14, 8'h9C);
        rd_reg(8'h15, 8'h03);
        wr_reg(8'h18, 8'h08);
        chk_out(4'h4);
        par_ack_n <= 1'b1;
        cyc(3);
        rd_reg(8'h14, 8'h9E);
        {u1, u2, fdc, wdt, ms, kb, par_act, par_ack_n} <= 8'h00;
        chk_out(4'hC);
        rd_reg(8'h14, 8'h02);
        wr_reg(8'h18, 8'h00);
        $display("test mirrors done");
        ir <= 1'b1;
        cyc(3);
        rd_reg(8'h15, 8'h04);
        rd_reg(8'h15, 8'h00);
        ir <= 1'b0;
        wr_reg(8'h19, 8'h04);
        chk_out(4'h4);
        rd_reg(8'h15, 8'h04);
        chk_out(4'hC);
        click <= 1'b1;
        cyc(1);
        click <= 1'b0;
        cyc(3);
        wr_reg(8'h15, 8'h00);
        rd_reg(8'h15, 8'h10);
        wr_reg(8'h15, 8'h10);
        rd_reg(8'h15, 8'h00);
        wr_reg(8'h19, 8'h00);
        $display("test infrared and click done");
        pins <= 11'h7FF;
        uhi <= 4'hF;
        cyc(1);
        pins <= 11'h000;
        uhi <= 4'h0;
        cyc(3);
        rd_reg(8'h16, 8'hFE);
        rd_reg(8'h17, 8'hFF);
        wr_reg(8'h16, 8'h01);
        rd_reg(8'h16, 8'hFE);
        wr_reg(8'h1A, 8'h02);
        chk_out(4'h4);
        wr_reg(8'h16, 8'h02);
        chk_out(4'hC);
        rd_reg(8'h16, 8'hFC);
        wr_reg(8'h1B, 8'h40);
        chk_out(4'h4);
        wr_reg(8'h17, 8'h0F);
        rd_reg(8'h17, 8'hF0);
        wr_reg(8'h17, 8'hF0);
        chk_out(4'hC);
        wr_reg(8'h16, 8'hFC);
        rd_reg(8'h16, 8'h00);
        $display("test pin events done");
        sag <= 1'b1;
        main_rst <= 1'b1;
        cyc(2);
        main_rst <= 1'b0;
        cyc(2);
        sag <= 1'b0;
        rd_reg(8'h14, 8'h03);
        wr_reg(8'h14, 8'h00);
        rd_reg(8'h14, 8'h03);
        wr_reg(8'h14, 8'h01);
        rd_reg(8'h14, 8'h02);
        // enable set first so the reset clear is visible
        wr_reg(8'h18, 8'h01);
        vbat_evt <= 1'b1;
        rst <= 1'b1;
        cyc(10);
        rst <= 1'b0;
        cyc(2);
        vbat_evt <= 1'b0;
        rd_reg(8'h14, 8'h03);
        rd_reg(8'h18, 8'h00);
        chk_out(4'hC);
        $display("test battery done");
        test_done();
    end
endmodule
